// *** logic/s3fa_framer.v ***
// Receive STS-3 framing alignment state machine with register slave
// Contract
// R1: In LOF-only state, check A1/A2 each frame
// R2: Four-bit R/W in-sync threshold at 0x112B
// R3: Clear LOF only after threshold error-free frames
// R4: Below threshold, stay LOF-only and keep testing
// R5: Four errored frames return to SEF+LOF state
// R6: Threshold reached: clear LOF, enter In-Frame
// R7: Clear status bit 2 on that transition
// R8: Raise LOF-change interrupt, bit 2, pin low
// R9: Start in SEF+LOF; two good frames clear SEF
// R10: In-Frame: four errored frames declare SEF
// R11: SEF-only for 3 ms declares LOF
// R12: SEF-only: two good frames return In-Frame
// R13: Errored frame zeroes good-frame counter
// R14: Reading interrupt status clears it; pin releases
//
// Added by the designer: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "s3fa_defs.vh"

module s3fa_framer #(
  parameter integer SEF_LOF_CYCLES = `S3FA_SEF_LOF_US * `S3FA_CLK_MHZ
) (
  input  wire        clk_sys_in,
  input  wire        rst_n_in,
  input  wire        frame_strobe_in,
  input  wire        frame_err_in,
  input  wire        wb_cyc_in,
  input  wire        wb_stb_in,
  input  wire        wb_we_in,
  input  wire [15:0] wb_adr_in,
  input  wire [31:0] wb_dat_in,
  input  wire [3:0]  wb_sel_in,
  output reg  [31:0] wb_dat_out,
  output reg         wb_ack_out,
  output wire        irq_n_out,
  output wire        sef_out,
  output wire        lof_out
);

  // =============================================================
  // State codes
  localparam [1:0] ST_SEF_LOF  = 2'b00;
  localparam [1:0] ST_LOF_ONLY = 2'b01;
  localparam [1:0] ST_IN_FRAME = 2'b10;
  localparam [1:0] ST_SEF_ONLY = 2'b11;

  reg  [1:0] state;
  reg  [1:0] next_state;
  reg  [3:0] good_cnt;
  reg  [3:0] next_good_cnt;
  reg  [1:0] err_cnt;
  reg  [1:0] next_err_cnt;
  reg  [3:0] sync_thr;
  reg  [7:0] irq_status;
  reg  [7:0] irq_mask;
  reg        sef_change;
  reg        lof_change;
  wire       sef_expired;
  wire       good_run;
  wire       err_run;
  wire [3:0] thr_eff;
  wire       thr_met;
  wire       bus_req;
  wire       bus_wr;
  wire       bus_rd;
  wire       rd_irq;
  wire [7:0] status_byte;
  wire [7:0] irq_set;
  wire [7:0] irq_wclr;

  // Matches a word address against a register index
  function addr_hit;
    input [15:0] adr;
    input [13:0] idx;
    begin
      addr_hit = (adr[15:2] == idx);
    end
  endfunction

  // =============================================================
  // Frame run detection
  assign good_run = frame_strobe_in && !frame_err_in &&
                    (good_cnt >= 4'h1);
  assign err_run  = frame_strobe_in && frame_err_in &&
                    (err_cnt == 2'h3);
  // A zero threshold is taken as one frame
  assign thr_eff  = (sync_thr == 4'h0) ? 4'h1 : sync_thr;
  assign thr_met  = frame_strobe_in && !frame_err_in &&
                    (good_cnt + 4'h1 >= thr_eff);

  // SEF persistence timer runs only in the SEF-only state
  s3fa_sef_timer #(
    .CYCLES (SEF_LOF_CYCLES)
  ) u_sef_timer (
    .clk_sys_in  (clk_sys_in),
    .rst_n_in    (rst_n_in),
    .run_in      (state == ST_SEF_ONLY),
    .expired_out (sef_expired)
  );

  // =============================================================
  // Next state, counters and change events
  always @* begin
    next_state    = state; // R4
    next_good_cnt = good_cnt;
    next_err_cnt  = err_cnt;
    sef_change    = 1'b0;
    lof_change    = 1'b0;
    if (frame_strobe_in) begin
      if (frame_err_in) begin
        next_good_cnt = 4'h0; // R13
        if (err_cnt != 2'h3) begin
          next_err_cnt = err_cnt + 2'h1;
        end
      end else begin
        next_err_cnt = 2'h0;
        if (good_cnt != 4'hF) begin
          next_good_cnt = good_cnt + 4'h1;
        end
      end
    end
    case (state)
      ST_SEF_LOF: begin
        if (good_run) begin // R9
          next_state = ST_LOF_ONLY;
          sef_change = 1'b1;
        end
      end
      ST_LOF_ONLY: begin // R1
        if (err_run) begin // R5
          next_state = ST_SEF_LOF;
          sef_change = 1'b1;
        end else if (thr_met) begin // R3 R6
          next_state = ST_IN_FRAME;
          lof_change = 1'b1; // R8
        end
        // Otherwise stay and keep counting
      end
      ST_IN_FRAME: begin
        if (err_run) begin // R10
          next_state = ST_SEF_ONLY;
          sef_change = 1'b1;
        end
      end
      ST_SEF_ONLY: begin
        if (good_run) begin // R12
          next_state = ST_IN_FRAME;
          sef_change = 1'b1;
        end else if (sef_expired) begin // R11
          next_state = ST_SEF_LOF;
          lof_change = 1'b1;
        end
      end
      default: begin
        next_state = ST_SEF_LOF;
      end
    endcase
    // Each new state starts its runs afresh
    if (next_state != state) begin
      next_good_cnt = 4'h0;
      next_err_cnt  = 2'h0;
    end
  end

  // State register; powers up with SEF and LOF declared
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state    <= ST_SEF_LOF; // R9
      good_cnt <= 4'h0;
      err_cnt  <= 2'h0;
    end else begin
      state    <= next_state;
      good_cnt <= next_good_cnt;
      err_cnt  <= next_err_cnt;
    end
  end

  // =============================================================
  // Defect status derived from state
  assign sef_out = (state == ST_SEF_LOF) || (state == ST_SEF_ONLY);
  assign lof_out = (state == ST_SEF_LOF) || (state == ST_LOF_ONLY); // R7
  assign status_byte = {5'h00, lof_out, sef_out, 1'b0};

  // =============================================================
  // Wishbone slave, one wait cycle, ack for one cycle
  assign bus_req = wb_cyc_in && wb_stb_in && !wb_ack_out;
  assign bus_wr  = bus_req && wb_we_in && wb_sel_in[0];
  assign bus_rd  = bus_req && !wb_we_in;
  assign rd_irq  = bus_rd && addr_hit(wb_adr_in, `S3FA_IDX_IRQ_STATUS);

  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else begin
      wb_ack_out <= bus_req;
      wb_dat_out <= 32'h0000_0000;
      if (bus_rd) begin
        if (addr_hit(wb_adr_in, `S3FA_IDX_STATUS)) begin
          wb_dat_out <= {24'h00_0000, status_byte};
        end else if (addr_hit(wb_adr_in, `S3FA_IDX_IRQ_STATUS)) begin
          wb_dat_out <= {24'h00_0000, irq_status};
        end else if (addr_hit(wb_adr_in, `S3FA_IDX_SYNC_THR)) begin
          wb_dat_out <= {28'h000_0000, sync_thr}; // R2
        end else if (addr_hit(wb_adr_in, `S3FA_IDX_IRQ_MASK)) begin
          wb_dat_out <= {24'h00_0000, irq_mask};
        end
      end
    end
  end

  // Writable registers
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync_thr <= `S3FA_RST_SYNC_THR;
      irq_mask <= `S3FA_RST_IRQ_MASK;
    end else if (bus_wr) begin
      if (addr_hit(wb_adr_in, `S3FA_IDX_SYNC_THR)) begin
        sync_thr <= wb_dat_in[`S3FA_THR_MSB:0]; // R2
      end
      if (addr_hit(wb_adr_in, `S3FA_IDX_IRQ_MASK)) begin
        irq_mask <= wb_dat_in[7:0];
      end
    end
  end

  // =============================================================
  // Interrupt status: set wins over read or write-one clear
  assign irq_set  = {5'h00, lof_change, sef_change, 1'b0};
  assign irq_wclr = (bus_wr &&
                     addr_hit(wb_adr_in, `S3FA_IDX_IRQ_STATUS)) ?
                    wb_dat_in[7:0] : 8'h00;

  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_status <= 8'h00;
    end else if (rd_irq) begin
      irq_status <= irq_set; // R14
    end else begin
      irq_status <= (irq_status & ~irq_wclr) | irq_set; // R8
    end
  end

  // Active-low pin low while any enabled bit is set
  assign irq_n_out = ~|(irq_status & irq_mask); // R8 R14

endmodule

`default_nettype wire

// *** logic/s3fa_defs.vh ***
// Constants for the receive STS-3 framing alignment block
`ifndef S3FA_DEFS_VH
`define S3FA_DEFS_VH

// =============================================================
// Register indices (byte address is four times the index)
`define S3FA_IDX_STATUS     14'h1107
`define S3FA_IDX_IRQ_STATUS 14'h110B
`define S3FA_IDX_SYNC_THR   14'h112B
`define S3FA_IDX_IRQ_MASK   14'h1110

// =============================================================
// Field positions
`define S3FA_BIT_SEF        1
`define S3FA_BIT_LOF        2
`define S3FA_THR_MSB        3

// =============================================================
// Reset values
`define S3FA_RST_SYNC_THR   4'h8
`define S3FA_RST_IRQ_MASK   8'h06

// =============================================================
// Timing
`define S3FA_CLK_MHZ        250
`define S3FA_SEF_LOF_US     3000
`define S3FA_ERR_RUN        4
`define S3FA_GOOD_RUN       2

`endif

// *** logic/s3fa_sef_timer.v ***
// Persistence timer for a declared SEF condition
`timescale 1ns/1ps
`default_nettype none

module s3fa_sef_timer #(
  parameter integer CYCLES = 750000
) (
  input  wire       clk_sys_in,
  input  wire       rst_n_in,
  input  wire       run_in,
  output reg        expired_out
);

  reg  [23:0] count;

  // =============================================================
  // Counts while running; restarts whenever run falls
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count       <= 24'h00_0000;
      expired_out <= 1'b0;
    end else if (!run_in) begin
      count       <= 24'h00_0000;
      expired_out <= 1'b0;
    end else begin
      expired_out <= (count == CYCLES[23:0] - 24'h00_0002);
      if (count != CYCLES[23:0] - 24'h00_0001) begin
        count <= count + 24'h00_0001;
      end
    end
  end

endmodule

`default_nettype wire

// *** tb/s3fa_line_model.sv ***
// Line-side source of received frame markers
`timescale 1ns/1ps
`default_nettype none

module s3fa_line_model (
  input  wire logic clk_sys_in,
  output var  logic frame_strobe_out,
  output var  logic frame_err_out
);
  // Idle: no strobe, error line flipped so stale values never pass
  initial begin
    frame_strobe_out = 1'b0;
    frame_err_out    = 1'b1;
  end
  // Sends n frames on back-to-back clocks, all good or all errored
  task automatic send(input int n, input logic bad);
    repeat (n) begin
      @(posedge clk_sys_in);
      frame_strobe_out <= 1'b1;
      frame_err_out    <= bad;
    end
    @(posedge clk_sys_in);
    frame_strobe_out <= 1'b0;
    frame_err_out    <= ~bad;
  endtask
endmodule
`default_nettype wire

// *** tb/s3fa_framer_chk.sv ***
// Port checker for the framing alignment block
`timescale 1ns/1ps
`default_nettype none

module s3fa_framer_chk (
  input wire logic        clk_sys_in,
  input wire logic        rst_n_in,
  input wire logic        frame_strobe_in,
  input wire logic        frame_err_in,
  input wire logic        wb_cyc_in,
  input wire logic        wb_stb_in,
  input wire logic        wb_we_in,
  input wire logic [15:0] wb_adr_in,
  input wire logic        wb_ack_out,
  input wire logic        irq_n_out,
  input wire logic        sef_out,
  input wire logic        lof_out
);
  default clocking dc @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  // Good frame, new request, status read with no event pending
  wire good = frame_strobe_in && !frame_err_in;
  wire req = wb_cyc_in && wb_stb_in && !wb_ack_out;
  wire irq_rd = req && !wb_we_in && wb_adr_in[15:2] == 14'h110b &&
    !frame_strobe_in && !(sef_out && !lof_out);
  // ==========================================================
  // Bus, state and interrupt relations
  a_ack_one_pulse: assert property (req |=> wb_ack_out ##1 !wb_ack_out)
    else $error("ack not a single pulse after request");
  a_lof_clear_cause: assert property ($fell(lof_out) |->
    $past(good) && !$past(sef_out)) else $error("lof cleared badly");
  a_lof_clear_irq: assert property ($fell(lof_out) |-> !irq_n_out)
    else $error("no interrupt on lof clear");
  a_sef_clear_cause: assert property ($fell(sef_out) |-> $past(good))
    else $error("sef cleared without good frame");
  a_sef_set_cause: assert property ($rose(sef_out) |->
    $past(frame_strobe_in && frame_err_in)) else $error("sef set badly");
  a_err_run_four: assert property ((!sef_out && lof_out &&
    frame_strobe_in && frame_err_in)[*4] |=> sef_out && lof_out)
    else $error("four errored frames kept lof-only state");
  a_lof_set_sef: assert property ($rose(lof_out) |-> $past(sef_out))
    else $error("lof declared outside sef-only state");
  a_quiet_hold: assert property (!frame_strobe_in &&
    !(sef_out && !lof_out) |=> $stable(sef_out) && $stable(lof_out))
    else $error("state moved without a frame");
  a_irq_read_clr: assert property (irq_rd |=> irq_n_out)
    else $error("interrupt held after status read");
endmodule

bind s3fa_framer s3fa_framer_chk chk (.clk_sys_in(clk_sys_in),
  .rst_n_in(rst_n_in), .frame_strobe_in(frame_strobe_in),
  .frame_err_in(frame_err_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
  .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_ack_out(wb_ack_out),
  .irq_n_out(irq_n_out), .sef_out(sef_out), .lof_out(lof_out));
`default_nettype wire

// *** tb/test_s3fa_framer.sv ***
// Register-level testbench for the framing alignment block
`timescale 1ns/1ps
`default_nettype none

module test_s3fa_framer;
  localparam integer slc = 40;
  localparam logic [15:0] st_a = 16'h441c, is_a = 16'h442c;
  localparam logic [15:0] th_a = 16'h44ac, mk_a = 16'h4440;
  logic        clk_sys_in, rst_n_in, cyc, stb, we, ack, irq_n, sef, lof;
  logic        strobe, ferr;
  logic [15:0] adr;
  logic [31:0] dat, rdat;
  logic [3:0]  sel;
  int          err_count, compares;

  s3fa_framer #(.SEF_LOF_CYCLES(slc)) dut (.clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in), .frame_strobe_in(strobe), .frame_err_in(ferr),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
    .wb_dat_in(dat), .wb_sel_in(sel), .wb_dat_out(rdat), .wb_ack_out(ack),
    .irq_n_out(irq_n), .sef_out(sef), .lof_out(lof));
  s3fa_line_model lm (.clk_sys_in(clk_sys_in), .frame_strobe_out(strobe),
    .frame_err_out(ferr));

  // ==========================================================
  // Compare, bus cycle and verdict tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic [15:0] a, input logic w,
                     input logic [7:0] d, input logic [7:0] exp);
    int n;
    n = 0;
    @(posedge clk_sys_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= {24'h00_0000, d};
    // Hold the request until ack is sampled high at a rising edge
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (ack !== 1'b1 && n < 20);
    chk({7'h00, ack}, 8'h01);
    if (!w) chk(rdat[7:0], exp);
    if (!w) chk({7'h00, |rdat[31:8]}, 8'h00);
    if (!w && a == st_a) chk({5'h00, lof, sef, 1'b0}, exp);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    bus(a, 1'b0, 8'h00, exp);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus(a, 1'b1, d, 8'h00);
  endtask
  task automatic ckirq(input logic exp);
    @(negedge clk_sys_in);
    chk({7'h00, irq_n}, {7'h00, exp});
  endtask
  task automatic conclude;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Clock and watchdog
  initial begin
    clk_sys_in = 1'b0;
    forever #2 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    repeat (4000) @(posedge clk_sys_in);
    err_count++;
    conclude();
  end

  // Main sequence through every framing state
  initial begin
    {err_count, compares} = 0;
    {rst_n_in, cyc, stb, we, adr, dat} = 0;
    sel = 4'hf;
    repeat (16) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    rd(st_a, 8'h06);
    rd(th_a, 8'h08);
    rd(is_a, 8'h00);
    lm.send(2, 1'b0);
    rd(st_a, 8'h04);
    ckirq(1'b0);
    rd(is_a, 8'h02);
    ckirq(1'b1);
    wr(th_a, 8'hf3);
    rd(th_a, 8'h03);
    rd(16'h0000, 8'h00);
    lm.send(2, 1'b0);
    lm.send(1, 1'b1);
    lm.send(2, 1'b0);
    rd(st_a, 8'h04);
    lm.send(1, 1'b0);
    rd(st_a, 8'h00);
    ckirq(1'b0);
    rd(is_a, 8'h04);
    lm.send(4, 1'b1);
    rd(st_a, 8'h02);
    lm.send(2, 1'b0);
    rd(st_a, 8'h00);
    rd(is_a, 8'h02);
    lm.send(4, 1'b1);
    repeat (slc + 8) @(posedge clk_sys_in);
    rd(st_a, 8'h06);
    rd(is_a, 8'h06);
    lm.send(2, 1'b0);
    lm.send(4, 1'b1);
    rd(st_a, 8'h06);
    rd(is_a, 8'h02);
    wr(mk_a, 8'h00);
    lm.send(2, 1'b0);
    ckirq(1'b1);
    wr(mk_a, 8'h06);
    ckirq(1'b0);
    wr(is_a, 8'h02);
    ckirq(1'b1);
    wr(th_a, 8'h00);
    rd(th_a, 8'h00);
    lm.send(1, 1'b0);
    rd(st_a, 8'h00);
    rd(is_a, 8'h04);
    conclude();
  end
endmodule
`default_nettype wire
